// *** rca_channel_regs.sv ***
// Per-lane reset controls and loss flags behind the lane select register
//
// Summary of operation
// - Four lanes each own an identical reset and event register pair.
// - Select register steers all later accesses other than FF until rewritten.
// - Address FF always hits only the select register.
// - Register 0 bit 3 holds the lane core state machine reset.
// - Register 0 bit 2 restores every lane register field to default.
// - Register 0 bit 1 holds the lane reference domain in reset.
// - Register 0 bit 0 holds the divided oscillator domain in reset.
// - Register 1 bit 4 flags lock lost after lock; read clears it.
// - Register 1 bit 0 flags signal lost after detection; read only.
// - Lane registers reachable only with select bit 2 set, else shared.
// - Select bit 3 broadcasts lane writes; reads use lane in bits 1:0.
`timescale 1ns/10ps
`include "rca_map.svh"

module rca_channel_regs (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic [7:0]         acc_addr,
  input  wire logic               acc_wr,
  input  wire logic               acc_rd,
  input  wire logic [7:0]         acc_wdata,
  input  wire logic [7:0]         shared_rdata,
  input  wire logic [3:0]         cdr_lock,
  input  wire logic [3:0]         sig_detect,
  output logic [7:0]              acc_rdata_r,
  output logic                    acc_rvalid_r,
  output logic                    shared_wr_r,
  output logic                    shared_rd_r,
  output logic [7:0]              shared_addr_r,
  output logic [7:0]              shared_wdata_r,
  output logic [3:0]              core_reset_r,
  output logic [3:0]              reference_domain_reset_r,
  output logic [3:0]              divided_oscillator_domain_reset_r,
  output logic [3:0]              lock_lost_r,
  output logic [3:0]              signal_lost_flag_r
);

  // Lane access only with enable bit set; FF is never a lane register
  function automatic logic lane_access(input rca_pkg::rca_byte_t sel,
                                       input rca_pkg::rca_byte_t addr);
    lane_access = sel[`RCA_SEL_EN_BIT] && (addr != `RCA_SEL_ADDR);
  endfunction : lane_access

  // Reads never broadcast: only the indexed lane answers
  function automatic logic lane_read_hit(input rca_pkg::rca_byte_t sel,
                                         input rca_pkg::rca_lane_t lane);
    lane_read_hit = (sel[`RCA_SEL_IDX_HI:`RCA_SEL_IDX_LO] == lane);
  endfunction : lane_read_hit

  function automatic logic lane_write_hit(input rca_pkg::rca_byte_t sel,
                                          input rca_pkg::rca_lane_t lane);
    lane_write_hit = sel[`RCA_SEL_BCAST_BIT] ||
      lane_read_hit(sel, lane);
  endfunction : lane_write_hit

  // Select register
  rca_pkg::rca_byte_t sel_r;
  rca_pkg::rca_byte_t sel_nxt;

  // Pin synchronisers; first stage feeds only the second
  rca_pkg::rca_lanes_t lock_s1_r;
  rca_pkg::rca_lanes_t lock_s2_r;
  rca_pkg::rca_lanes_t lock_d_r;
  rca_pkg::rca_lanes_t sig_s1_r;
  rca_pkg::rca_lanes_t sig_s2_r;
  rca_pkg::rca_lanes_t sig_d_r;
  rca_pkg::rca_lanes_t lock_s1_nxt;
  rca_pkg::rca_lanes_t lock_s2_nxt;
  rca_pkg::rca_lanes_t lock_d_nxt;
  rca_pkg::rca_lanes_t sig_s1_nxt;
  rca_pkg::rca_lanes_t sig_s2_nxt;
  rca_pkg::rca_lanes_t sig_d_nxt;

  // Registered lane outputs, one group for all lanes
  rca_pkg::rca_lanes_t core_rst_nxt;
  rca_pkg::rca_lanes_t ref_rst_nxt;
  rca_pkg::rca_lanes_t vco_rst_nxt;
  rca_pkg::rca_lanes_t lock_lost_nxt;
  rca_pkg::rca_lanes_t sig_lost_nxt;

  // Per-lane storage
  rca_pkg::rca_byte_t rst_reg_r [`RCA_NUM_CH];
  rca_pkg::rca_byte_t rst_reg_nxt [`RCA_NUM_CH];
  rca_pkg::rca_byte_t evt_reg_r [`RCA_NUM_CH];
  rca_pkg::rca_byte_t evt_reg_nxt [`RCA_NUM_CH];

  // Bus answer group
  rca_pkg::rca_byte_t rdata_nxt;
  logic               rvalid_nxt;
  logic               sh_wr_nxt;
  logic               sh_rd_nxt;
  rca_pkg::rca_byte_t sh_addr_nxt;
  rca_pkg::rca_byte_t sh_wdata_nxt;
  rca_pkg::rca_lane_t rd_lane;

  // Pins are asynchronous; two stages before any decode
  always_comb begin
    lock_s1_nxt = cdr_lock;
    lock_s2_nxt = lock_s1_r;
    lock_d_nxt  = lock_s2_r;
    sig_s1_nxt  = sig_detect;
    sig_s2_nxt  = sig_s1_r;
    sig_d_nxt   = sig_s2_r;
  end

  // Edge stage resets low so no false fall follows reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_s1_r <= 4'h0;
      lock_s2_r <= 4'h0;
      lock_d_r  <= 4'h0;
      sig_s1_r  <= 4'h0;
      sig_s2_r  <= 4'h0;
      sig_d_r   <= 4'h0;
    end else begin
      lock_s1_r <= lock_s1_nxt;
      lock_s2_r <= lock_s2_nxt;
      lock_d_r  <= lock_d_nxt;
      sig_s1_r  <= sig_s1_nxt;
      sig_s2_r  <= sig_s2_nxt;
      sig_d_r   <= sig_d_nxt;
    end
  end

  always_comb begin
    sel_nxt = sel_r;
    // Selection changes only on a write to FF
    // FF decodes to the select register alone
    if (acc_wr && (acc_addr == `RCA_SEL_ADDR)) begin
      sel_nxt = acc_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_r <= `RCA_SEL_RESET;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // One identical register pair per lane
  genvar gi;
  generate
    for (gi = 0; gi < `RCA_NUM_CH; gi = gi + 1) begin : g_lane
      localparam rca_pkg::rca_lane_t LANE = 2'(gi);
      logic wr_hit;
      logic rd_hit;
      logic lock_fall;
      logic sig_fall;

      always_comb begin
        // Broadcast widens writes, reads stay on one lane
        wr_hit = acc_wr && lane_access(sel_r, acc_addr) &&
                 lane_write_hit(sel_r, LANE);
        rd_hit = acc_rd && lane_access(sel_r, acc_addr) &&
                 lane_read_hit(sel_r, LANE);
        lock_fall = lock_d_r[gi] && !lock_s2_r[gi];
        sig_fall  = sig_d_r[gi] && !sig_s2_r[gi];
        rst_reg_nxt[gi] = rst_reg_r[gi];
        evt_reg_nxt[gi] = evt_reg_r[gi];
        // Reset bits other than bit 2 stay until written back to zero
        if (wr_hit && (acc_addr == `RCA_CH_RST_ADDR)) begin
          rst_reg_nxt[gi] = acc_wdata;
        end

        // Reserved bits stored as written; flag bits host read only
        if (wr_hit && (acc_addr == `RCA_CH_EVT_ADDR)) begin
          evt_reg_nxt[gi][`RCA_EVT_RSV_HI:`RCA_EVT_RSV_LO] =
            acc_wdata[`RCA_EVT_RSV_HI:`RCA_EVT_RSV_LO];
        end
        if (rd_hit && (acc_addr == `RCA_CH_EVT_ADDR)) begin
          evt_reg_nxt[gi][`RCA_EVT_LOCK_BIT] = 1'b0;
        end

        // Set wins over the read clear
        if (lock_fall) begin
          evt_reg_nxt[gi][`RCA_EVT_LOCK_BIT] = 1'b1;
        end
        // Signal lost only after it was detected
        if (sig_fall) begin
          evt_reg_nxt[gi][`RCA_EVT_SIG_BIT] = 1'b1;
        end

        // Self-clearing, so the lane leaves register reset by itself
        // Register reset restores defaults, itself included
        if (rst_reg_r[gi][`RCA_RST_REGS_BIT]) begin
          rst_reg_nxt[gi] = `RCA_CH_RST_RESET;
          evt_reg_nxt[gi] = `RCA_CH_EVT_RESET;
        end
      end

      always_ff @(posedge core_clk) begin
        if (rst) begin
          rst_reg_r[gi] <= `RCA_CH_RST_RESET;
          evt_reg_r[gi] <= `RCA_CH_EVT_RESET;
        end else begin
          rst_reg_r[gi] <= rst_reg_nxt[gi];
          evt_reg_r[gi] <= evt_reg_nxt[gi];
        end
      end
    end
  endgenerate

  // Outputs follow the register value from the write edge on
  always_comb begin
    core_rst_nxt  = 4'h0;
    ref_rst_nxt   = 4'h0;
    vco_rst_nxt   = 4'h0;
    lock_lost_nxt = 4'h0;
    sig_lost_nxt  = 4'h0;
    for (int li = 0; li < `RCA_NUM_CH; li++) begin
      core_rst_nxt[li]  = rst_reg_nxt[li][`RCA_RST_CORE_BIT];
      ref_rst_nxt[li]   = rst_reg_nxt[li][`RCA_RST_REF_BIT];
      vco_rst_nxt[li]   = rst_reg_nxt[li][`RCA_DIVIDED_OSCILLATOR_DOMAIN_RESET_BIT];
      lock_lost_nxt[li] = evt_reg_nxt[li][`RCA_EVT_LOCK_BIT];
      sig_lost_nxt[li]  = evt_reg_nxt[li][`RCA_EVT_SIG_BIT];
    end
  end

  // All lane reset and flag outputs come straight from these flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      core_reset_r                      <= 4'h0;
      reference_domain_reset_r          <= 4'h0;
      divided_oscillator_domain_reset_r <= 4'h0;
      lock_lost_r                       <= 4'h0;
      signal_lost_flag_r                <= 4'h0;
    end else begin
      core_reset_r                      <= core_rst_nxt;
      reference_domain_reset_r          <= ref_rst_nxt;
      divided_oscillator_domain_reset_r <= vco_rst_nxt;
      lock_lost_r                       <= lock_lost_nxt;
      signal_lost_flag_r                <= sig_lost_nxt;
    end
  end

  assign rd_lane = sel_r[`RCA_SEL_IDX_HI:`RCA_SEL_IDX_LO];

  always_comb begin
    rdata_nxt    = `RCA_ZERO_BYTE;
    rvalid_nxt   = acc_rd;
    sh_wr_nxt    = 1'b0;
    sh_rd_nxt    = 1'b0;
    sh_addr_nxt  = acc_addr;
    sh_wdata_nxt = acc_wdata;
    if (acc_addr == `RCA_SEL_ADDR) begin
      // Select readback is deliberately invalid
      // Upper nibble stored as written; host must keep it zero
      rdata_nxt = `RCA_SEL_INVALID;
    end else if (lane_access(sel_r, acc_addr)) begin
      case (acc_addr)
        `RCA_CH_RST_ADDR: rdata_nxt = rst_reg_r[rd_lane];
        `RCA_CH_EVT_ADDR: rdata_nxt = evt_reg_r[rd_lane];
        default:          rdata_nxt = `RCA_ZERO_BYTE;
      endcase
    end else begin
      // Enable clear: access goes to the shared set
      // Shared set must answer combinationally in the read cycle
      sh_wr_nxt = acc_wr;
      sh_rd_nxt = acc_rd;
      rdata_nxt = shared_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_rdata_r    <= `RCA_ZERO_BYTE;
      acc_rvalid_r   <= 1'b0;
      shared_wr_r    <= 1'b0;
      shared_rd_r    <= 1'b0;
      shared_addr_r  <= `RCA_ZERO_BYTE;
      shared_wdata_r <= `RCA_ZERO_BYTE;
    end else begin
      acc_rdata_r    <= rdata_nxt;
      acc_rvalid_r   <= rvalid_nxt;
      shared_wr_r    <= sh_wr_nxt;
      shared_rd_r    <= sh_rd_nxt;
      shared_addr_r  <= sh_addr_nxt;
      shared_wdata_r <= sh_wdata_nxt;
    end
  end

endmodule : rca_channel_regs

// *** rca_map.svh ***
// Register offsets, field positions and reset values for channel access
`ifndef RCA_MAP_SVH
`define RCA_MAP_SVH

`define RCA_NUM_CH        4
`define RCA_SEL_ADDR      8'hFF
`define RCA_CH_RST_ADDR   8'h00
`define RCA_CH_EVT_ADDR   8'h01

`define RCA_SEL_RESET     8'h00
`define RCA_CH_RST_RESET  8'h00
`define RCA_CH_EVT_RESET  8'h00
`define RCA_SEL_INVALID   8'hFF
`define RCA_ZERO_BYTE     8'h00

`define RCA_SEL_IDX_HI    1
`define RCA_SEL_IDX_LO    0
`define RCA_SEL_EN_BIT    2
`define RCA_SEL_BCAST_BIT 3

`define RCA_RST_CORE_BIT  3
`define RCA_RST_REGS_BIT  2
`define RCA_RST_REF_BIT   1
`define RCA_DIVIDED_OSCILLATOR_DOMAIN_RESET_BIT   0

`define RCA_EVT_LOCK_BIT  4
`define RCA_EVT_SIG_BIT   0
`define RCA_EVT_RSV_HI    7
`define RCA_EVT_RSV_LO    5

`endif

// *** rca_pkg.sv ***
// Shared types for the channel register access block
package rca_pkg;
  typedef logic [7:0] rca_byte_t;
  typedef logic [1:0] rca_lane_t;
  typedef logic [3:0] rca_lanes_t;
endpackage : rca_pkg

// *** rca_channel_regs_chk.sv ***
// Concurrent checks on the lane register access block
`timescale 1ns/10ps
module rca_channel_regs_chk (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] acc_addr,
  input wire logic       acc_wr,
  input wire logic       acc_rd,
  input wire logic [7:0] acc_wdata,
  input wire logic [3:0] cdr_lock,
  input wire logic [7:0] acc_rdata_r,
  input wire logic       acc_rvalid_r,
  input wire logic       shared_wr_r,
  input wire logic       shared_rd_r,
  input wire logic [3:0] core_reset_r,
  input wire logic [3:0] reference_domain_reset_r,
  input wire logic [3:0] divided_oscillator_domain_reset_r,
  input wire logic [3:0] lock_lost_r
);
  logic [7:0] sel_r;
  logic [7:0] sel_nxt;
  logic       lane_wr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shadow of the select byte, since it cannot be read back
  always_comb begin
    sel_nxt = sel_r;
    if (acc_wr && acc_addr == 8'hFF) sel_nxt = acc_wdata;
    lane_wr = acc_wr && sel_r[2] && acc_addr == 8'h00;
  end
  always_ff @(posedge core_clk) sel_r <= rst ? 8'h00 : sel_nxt;
  AST_RD_ANSWER: assert property (acc_rd |=> acc_rvalid_r)
    else $error("read not answered next cycle");
  AST_RD_QUIET: assert property (!acc_rd |=> !acc_rvalid_r)
    else $error("read valid without a read");
  AST_SEL_LOCAL: assert property ((acc_wr || acc_rd) && acc_addr == 8'hFF
    |=> !shared_wr_r && !shared_rd_r) else $error("select access forwarded");
  AST_SEL_RDBK: assert property (acc_rd && acc_addr == 8'hFF
    |=> acc_rdata_r == 8'hFF) else $error("select readback not invalid");
  AST_SHARED: assert property (acc_wr && acc_addr != 8'hFF && !sel_r[2]
    |=> shared_wr_r) else $error("shared write not forwarded");
  AST_SHARED_RD: assert property (acc_rd && acc_addr != 8'hFF && !sel_r[2]
    |=> shared_rd_r) else $error("shared read not forwarded");
  AST_LANE_HIDE: assert property ((acc_wr || acc_rd) && sel_r[2]
    |=> !shared_wr_r && !shared_rd_r) else $error("lane access leaked");
  AST_CORE: assert property (lane_wr && !acc_wdata[2]
    |=> core_reset_r[sel_r[1:0]] == $past(acc_wdata[3]))
    else $error("core reset output wrong");
  AST_REF_VCO: assert property (lane_wr && !acc_wdata[2] |=>
    reference_domain_reset_r[sel_r[1:0]] == $past(acc_wdata[1]) &&
    divided_oscillator_domain_reset_r[sel_r[1:0]] == $past(acc_wdata[0]))
    else $error("domain reset output wrong");
  AST_REGRST: assert property (lane_wr && acc_wdata[2] |-> ##2
    core_reset_r[sel_r[1:0]] == 1'b0 &&
    reference_domain_reset_r[sel_r[1:0]] == 1'b0)
    else $error("register reset did not clear");
  AST_HOLD: assert property ($fell(core_reset_r[0])
    |-> $past(acc_wr) || $past(acc_wr, 2)) else $error("reset dropped alone");
  AST_LOCK_SET: assert property ($fell(cdr_lock[2])
    |-> ##[2:4] lock_lost_r[2]) else $error("lock loss not flagged");
  cover property (lane_wr && sel_r[3]);
  cover property (acc_rd && sel_r[2] && acc_addr == 8'h01 && lock_lost_r[2]);
  cover property (acc_wr && !sel_r[2]);
endmodule : rca_channel_regs_chk

bind rca_channel_regs rca_channel_regs_chk chk_u (.core_clk, .rst,
  .acc_addr, .acc_wr, .acc_rd, .acc_wdata, .cdr_lock, .acc_rdata_r,
  .acc_rvalid_r, .shared_wr_r, .shared_rd_r, .core_reset_r,
  .reference_domain_reset_r, .divided_oscillator_domain_reset_r,
  .lock_lost_r);

// *** rca_shared_model.sv ***
// Behavioural shared register set on the far side of the lane block
`timescale 1ns/10ps
module rca_shared_model (
  input wire logic        core_clk,
  input wire logic        shared_wr_r,
  input wire logic [7:0]  shared_addr_r,
  input wire logic [7:0]  shared_wdata_r,
  input wire logic [7:0]  acc_addr,
  output logic [7:0]      shared_rdata
);
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
  always @(posedge core_clk) if (shared_wr_r) mem[shared_addr_r] <= shared_wdata_r;
  assign shared_rdata = mem[acc_addr];
endmodule : rca_shared_model

// *** tb_retimer_channel_reg_access.sv ***
// Directed bench for the lane register access block
`timescale 1ns/10ps
module tb_retimer_channel_reg_access;
  logic       core_clk, rst, acc_wr, acc_rd, acc_rvalid_r, shared_wr_r;
  logic       shared_rd_r;
  logic [7:0] acc_addr, acc_wdata, shared_rdata, acc_rdata_r;
  logic [7:0] shared_addr_r, shared_wdata_r;
  logic [3:0] cdr_lock, sig_detect, core_reset_r, reference_domain_reset_r;
  logic [3:0] divided_oscillator_domain_reset_r, lock_lost_r;
  logic [3:0] signal_lost_flag_r;
  int         fails, total_checks;
  rca_channel_regs dut_u (.core_clk, .rst, .acc_addr, .acc_wr, .acc_rd,
    .acc_wdata, .shared_rdata, .cdr_lock, .sig_detect, .acc_rdata_r,
    .acc_rvalid_r, .shared_wr_r, .shared_rd_r, .shared_addr_r,
    .shared_wdata_r, .core_reset_r, .reference_domain_reset_r,
    .divided_oscillator_domain_reset_r, .lock_lost_r, .signal_lost_flag_r);
  rca_shared_model far_u (.core_clk, .shared_wr_r, .shared_addr_r,
    .shared_wdata_r, .acc_addr, .shared_rdata);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    acc_addr <= a;
    acc_wdata <= d;
    acc_wr <= 1'b1;
    @(posedge core_clk);
    acc_wr <= 1'b0;
    #1;
  endtask : wr
  // One idle cycle after each read keeps strobes from colliding
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    acc_addr <= a;
    acc_rd <= 1'b1;
    @(posedge core_clk);
    acc_rd <= 1'b0;
    #1;
    chk("rvalid", {7'h00, acc_rvalid_r}, 8'h01);
    chk("rdata", acc_rdata_r, exp);
  endtask : rd
  task t_route;
    chk("siglost", {4'h0, signal_lost_flag_r}, 8'h00);
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h5A);
    rd(8'hFF, 8'hFF);
    wr(8'hFF, 8'h04);
    wr(8'h00, 8'h08);
    chk("core", {4'h0, core_reset_r}, 8'h01);
    rd(8'h00, 8'h08);
    rd(8'h10, 8'h00);
    wr(8'hFF, 8'h05);
    wr(8'h00, 8'h03);
    chk("ref", {4'h0, reference_domain_reset_r}, 8'h02);
    chk("vco", {4'h0, divided_oscillator_domain_reset_r}, 8'h02);
    chk("core", {4'h0, core_reset_r}, 8'h01);
    $display("route test ended");
  endtask : t_route
  task t_bcast;
    wr(8'hFF, 8'h0D);
    wr(8'h00, 8'h02);
    chk("ref", {4'h0, reference_domain_reset_r}, 8'h0F);
    chk("core", {4'h0, core_reset_r}, 8'h00);
    rd(8'h00, 8'h02);
    repeat (20) @(posedge core_clk);
    chk("ref", {4'h0, reference_domain_reset_r}, 8'h0F);
    wr(8'h00, 8'h00);
    chk("ref", {4'h0, reference_domain_reset_r}, 8'h00);
    $display("broadcast test ended");
  endtask : t_bcast
  task t_regrst;
    wr(8'hFF, 8'h04);
    wr(8'h01, 8'hE0);
    rd(8'h01, 8'hE0);
    wr(8'h00, 8'h0F);
    @(posedge core_clk);
    #1;
    chk("core", {4'h0, core_reset_r}, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h00, 8'h00);
    $display("register reset test ended");
  endtask : t_regrst
  task t_events;
    wr(8'hFF, 8'h06);
    @(posedge core_clk);
    cdr_lock <= 4'hB;
    sig_detect <= 4'hB;
    repeat (5) @(posedge core_clk);
    #1;
    chk("lock", {4'h0, lock_lost_r}, 8'h04);
    chk("siglost", {4'h0, signal_lost_flag_r}, 8'h04);
    rd(8'h01, 8'h11);
    chk("lock", {4'h0, lock_lost_r}, 8'h00);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h01);
    $display("event test ended");
  endtask : t_events
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  initial begin
    rst = 1'b1;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
    cdr_lock = 4'hF;
    sig_detect = 4'hF;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_route;
    t_bcast;
    t_regrst;
    t_events;
    close_out;
  end
  // Generous margin over the roughly 80 cycles the tests need
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    close_out;
  end
endmodule : tb_retimer_channel_reg_access
